// file: hw/cmb_pkg.sv
// Package: constants for the CAN message buffer manager
package cmb_pkg;
    // ********************************************************
    // Register offsets (byte addresses on the plain port)
    // ********************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;       // Control: stamp enable, init, loopback
    localparam logic [7:0] ADDR_TX_FLAG = 8'h01;    // tx_flag_reg
    localparam logic [7:0] ADDR_ABORT_REQ = 8'h02;  // abort_request_reg
    localparam logic [7:0] ADDR_ABORT_ACK = 8'h03;  // abort_ack_reg
    localparam logic [7:0] ADDR_TX_SEL = 8'h04;     // tx_buffer_select_reg
    localparam logic [7:0] ADDR_RX_FLAG = 8'h05;    // rx_flag_reg
    localparam logic [7:0] ADDR_TIMER_LO = 8'h06;   // Live timer, low byte
    localparam logic [7:0] ADDR_TIMER_HI = 8'h07;   // Live timer, high byte
    localparam logic [7:0] ADDR_RX_WIN = 8'h20;     // Foreground receive window base
    localparam logic [7:0] ADDR_TX_WIN = 8'h30;     // tx_buffer_window base
    // ********************************************************
    // Buffer layout
    // ********************************************************
    localparam int NUM_TX = 3;
    localparam int NUM_RX = 5;
    localparam int RX_BYTES = 15;
    localparam int TX_BYTES = 16;
    localparam logic [3:0] IDX_LOCAL_PRIORITY = 4'hD;         // Local priority byte in tx window
    localparam logic [3:0] IDX_STAMP_HI = 4'hE;
    localparam logic [3:0] IDX_STAMP_LO = 4'hF;
    localparam logic [3:0] RX_STAMP_HI = 4'hD;
    localparam logic [3:0] RX_STAMP_LO = 4'hE;
    // ********************************************************
    // Control and status bit positions
    // ********************************************************
    localparam int CTRL_STAMP = 0;
    localparam int CTRL_INIT = 1;
    localparam int CTRL_LOOP = 2;
    localparam int RXF_FULL = 0;
    localparam int RXF_OVR = 1;
    localparam logic [2:0] TX_FLAG_RST = 3'h7;      // All buffers empty after reset
    localparam logic [7:0] CTRL_RST = 8'h02;        // Start in init mode
    localparam logic [15:0] TIMER_RST = 16'h0000;
    // ********************************************************
    // Transmit state machine
    // ********************************************************
    typedef enum logic [1:0] {
        CMB_IDLE = 2'b00,
        CMB_ARB = 2'b01,
        CMB_SEND = 2'b11
    } cmb_tx_e;
endpackage

// file: hw/cmb_buffer_manager.sv
// Module: message storage of a CAN controller
`timescale 1ns/1ps
// Summary of operation
// - Stamp active buffer on acknowledge when enabled
// - Free-running bit-clock timer, no overflow flag
// - Timer held zero in init mode
// - Tx stamp read-only, gated by empty, select
// - Three tx buffers: 13 bytes, priority, stamp
// - Selected empty buffer mapped to window
// - Schedule ready buffers; set empty when sent
// - Lowest priority value sent first
// - Rescheduled at every arbitration, errors too
// - Abort idle buffer: ack, empty, interrupt
// - Ack flag tells aborted versus sent
// - Five-stage 15-byte rx fifo, foreground visible
// - Rx full while foreground holds message
// - Accepted frame shifted, full flag, interrupt
// - Invalid frame dropped, overwritten next
// - Own frames dropped unless loopback
// - Lost arbitration switches to receiving
// - Full fifo: discard, overrun interrupt
// - Transmit goes on while fifo full
// - Equal priority: lower index first
module cmb_buffer_manager (
    input wire logic i_clock,                       // 250 MHz core clock
    input wire logic i_rst,                         // Synchronous reset, active high
    input wire logic [7:0] i_addr,                  // Register address
    input wire logic [7:0] i_wdata,                 // Write data
    input wire logic i_wr,                          // Write strobe
    input wire logic i_rd,                          // Read strobe
    output logic [7:0] o_rdata,                     // Read data, one cycle after strobe
    input wire logic i_bit_tick,                    // One pulse per CAN bit time
    input wire logic i_sof,                         // Bus free, start of frame next
    input wire logic i_arb_lost,                    // Arbitration lost pulse
    input wire logic i_tx_error,                    // Transmission error pulse
    input wire logic i_tx_done,                     // Own frame acknowledged
    input wire logic i_rx_we,                       // Receive byte strobe
    input wire logic [3:0] i_rx_idx,                // Receive byte index
    input wire logic [7:0] i_rx_byte,               // Receive byte
    input wire logic i_rx_ok,                       // Frame acknowledged on bus
    input wire logic i_rx_accept,                   // Filter accepted identifier
    input wire logic i_rx_own,                      // Frame was our own
    input wire logic [3:0] i_txrd_idx,              // Transmit byte index
    output logic [7:0] o_tx_byte,                   // Transmit byte of active buffer
    output logic o_tx_req,                          // A buffer is being sent
    output logic o_receiving,                       // Receiving after lost arbitration
    output logic o_tx_irq,                          // Transmit event pulse
    output logic o_rx_irq,                          // Receive event pulse
    output logic o_ovr_irq,                         // Overrun event pulse
    output logic o_init_mode                        // Init mode level
);
    import cmb_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    // Software-visible registers
    logic [7:0] ctrl_q;
    logic [2:0] tx_empty_flag_q;
    logic [2:0] abort_request_q;
    logic [2:0] abort_acknowledge_q;
    logic [2:0] tx_buffer_select_reg_q;

    logic [15:0] timer_q;
    logic [7:0] tx_mem_q [NUM_TX][TX_BYTES];
    logic [7:0] rx_mem_q [NUM_RX][16];

    logic [2:0] bg_q;                               // Background slot index
    logic [2:0] fg_q;                               // Foreground slot index
    logic [2:0] cnt_q;                              // Messages held in the fifo
    logic rx_ovr_q;

    // Scheduler, output regs
    cmb_tx_e st_q;
    logic [1:0] act_q;                              // Buffer under transmission

    logic [7:0] rdata_q;
    logic [7:0] tx_byte_q;

    logic tx_irq_q;
    logic rx_irq_q;
    logic ovr_irq_q;

    logic recv_q;

    // ********************************************************
    // Decode
    // ********************************************************
    // Control fields
    wire stamp_en = ctrl_q[CTRL_STAMP];
    wire init_mode = ctrl_q[CTRL_INIT];
    wire loopback = ctrl_q[CTRL_LOOP];
    // One-hot select: lowest set bit picks the buffer
    wire [1:0] sel_idx = tx_buffer_select_reg_q[0] ? 2'd0 :
                         tx_buffer_select_reg_q[1] ? 2'd1 : 2'd2;
    wire sel_ok = (tx_buffer_select_reg_q != 3'h0) && tx_empty_flag_q[sel_idx];

    // Upper nibble picks a window
    wire tx_win = (i_addr[7:4] == ADDR_TX_WIN[7:4]);
    wire rx_win = (i_addr[7:4] == ADDR_RX_WIN[7:4]);
    wire [3:0] win_idx = i_addr[3:0];
    // Stamp bytes refuse writes; software never alters them
    wire tx_stamp_byte = (win_idx == IDX_STAMP_HI) || (win_idx == IDX_STAMP_LO);
    wire tx_win_wr = i_wr && tx_win && sel_ok && !tx_stamp_byte;

    wire rxfull = (cnt_q != 3'd0);
    wire fifo_full = (cnt_q == 3'(NUM_RX - 1));     // Background slot stays reserved

    // Priority pick among ready buffers, lower index on ties
    wire [2:0] ready = ~tx_empty_flag_q;

    wire [7:0] p0 = tx_mem_q[0][IDX_LOCAL_PRIORITY];
    wire [7:0] p1 = tx_mem_q[1][IDX_LOCAL_PRIORITY];
    wire [7:0] p2 = tx_mem_q[2][IDX_LOCAL_PRIORITY];
    wire w01 = !ready[1] || (ready[0] && p0 <= p1);
    wire [1:0] a01 = w01 ? 2'd0 : 2'd1;
    wire [7:0] pa = w01 ? p0 : p1;

    wire ra = ready[0] || ready[1];
    wire [1:0] win = (ra && (!ready[2] || pa <= p2)) ? a01 : 2'd2;

    // Frame end qualification
    wire rx_take = i_rx_ok && i_rx_accept && (!i_rx_own || loopback);
    wire rx_shift = rx_take && !fifo_full;
    wire rx_drop = rx_take && fifo_full;
    wire rd_release = i_wr && (i_addr == ADDR_RX_FLAG) && i_wdata[RXF_FULL] && rxfull;

    // Ring pointers wrap
    wire [2:0] bg_nx = (bg_q == 3'(NUM_RX - 1)) ? 3'd0 : bg_q + 3'd1;
    wire [2:0] fg_nx = (fg_q == 3'(NUM_RX - 1)) ? 3'd0 : fg_q + 3'd1;

    // Abort only buffers not on the wire
    logic [2:0] busy;
    always_comb begin
        busy = 3'h0;
        if (st_q == CMB_SEND) begin
            busy[act_q] = 1'b1;
        end
    end

    wire [2:0] abort_now = abort_request_q & ready & ~busy;

    // Frame outcome
    wire sent = (st_q == CMB_SEND) && i_tx_done;
    wire fail = (st_q == CMB_SEND) && (i_tx_error || i_arb_lost);

    // ********************************************************
    // Control registers
    // ********************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RST;
            tx_buffer_select_reg_q <= 3'h0;
        end else begin
            if (i_wr && i_addr == ADDR_CTRL) begin
                ctrl_q <= {5'h0, i_wdata[2:0]};
            end
            // Empty buffers only
            if (i_wr && i_addr == ADDR_TX_SEL) begin
                tx_buffer_select_reg_q <= i_wdata[2:0] & tx_empty_flag_q;
            end
        end
    end

    // ********************************************************
    // Timer
    // ********************************************************
    // Wraps from all ones to zero with no flag raised
    always_ff @(posedge i_clock) begin
        if (i_rst || init_mode) begin
            timer_q <= TIMER_RST;
        end else if (i_bit_tick) begin
            timer_q <= timer_q + 16'd1;
        end
    end

    // ********************************************************
    // Transmit flags, one bit per buffer
    // ********************************************************
    for (genvar b = 0; b < NUM_TX; b++) begin : g_tx
        // Hardware set beats clear
        wire done_b = sent && (act_q == 2'(b));
        wire clr_b = i_wr && (i_addr == ADDR_TX_FLAG) && i_wdata[b] && tx_empty_flag_q[b];
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                tx_empty_flag_q[b] <= TX_FLAG_RST[b];
                abort_request_q[b] <= 1'b0;
                abort_acknowledge_q[b] <= 1'b0;
            end else if (done_b) begin
                tx_empty_flag_q[b] <= 1'b1;
                abort_acknowledge_q[b] <= 1'b0;
                abort_request_q[b] <= 1'b0;
            end else if (abort_now[b]) begin
                tx_empty_flag_q[b] <= 1'b1;
                abort_acknowledge_q[b] <= 1'b1;
                abort_request_q[b] <= 1'b0;
            end else begin
                if (clr_b) begin
                    tx_empty_flag_q[b] <= 1'b0;
                    abort_acknowledge_q[b] <= 1'b0;
                end
                if (i_wr && i_addr == ADDR_ABORT_REQ && i_wdata[b] && !tx_empty_flag_q[b]) begin
                    abort_request_q[b] <= 1'b1;
                end
            end
        end
    end

    // ********************************************************
    // Transmit buffer storage and stamping
    // ********************************************************
    always_ff @(posedge i_clock) begin
        if (tx_win_wr) begin
            tx_mem_q[sel_idx][win_idx] <= i_wdata;
        end

        // Timer before this tick
        if (sent && stamp_en) begin
            tx_mem_q[act_q][IDX_STAMP_HI] <= timer_q[15:8];
            tx_mem_q[act_q][IDX_STAMP_LO] <= timer_q[7:0];
        end
    end

    // ********************************************************
    // Transmit scheduler
    // ********************************************************
    // Arbitration redone on every start of frame, errors included
    always_ff @(posedge i_clock) begin
        if (i_rst || init_mode) begin
            st_q <= CMB_IDLE;
            act_q <= 2'd0;
            recv_q <= 1'b0;
        end else begin
            case (st_q)
                CMB_IDLE: begin
                    if (ready != 3'h0) begin
                        st_q <= CMB_ARB;
                    end
                end
                CMB_ARB: begin
                    if (ready == 3'h0) begin
                        st_q <= CMB_IDLE;
                    end else if (i_sof) begin
                        act_q <= win;
                        st_q <= CMB_SEND;
                        recv_q <= 1'b0;
                    end
                end
                CMB_SEND: begin
                    if (sent) begin
                        st_q <= CMB_IDLE;
                    end else if (fail) begin
                        st_q <= CMB_ARB;
                        recv_q <= i_arb_lost;
                    end
                end
                default: st_q <= CMB_IDLE;
            endcase

            if (i_rx_ok) begin
                recv_q <= 1'b0;
            end
        end
    end

    // ********************************************************
    // Receive fifo
    // ********************************************************
    // Background slot is written live; bad frames are simply overwritten
    always_ff @(posedge i_clock) begin
        if (i_rx_we && i_rx_idx < 4'(RX_BYTES)) begin
            rx_mem_q[bg_q][i_rx_idx] <= i_rx_byte;
        end

        if (rx_shift && stamp_en) begin
            rx_mem_q[bg_q][RX_STAMP_HI] <= timer_q[15:8];
            rx_mem_q[bg_q][RX_STAMP_LO] <= timer_q[7:0];
        end
    end

    // Transmission is independent of this counter, so a full fifo never stalls it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bg_q <= 3'd0;
            fg_q <= 3'd0;
            cnt_q <= 3'd0;
            rx_ovr_q <= 1'b0;
        end else begin
            if (rx_shift) begin
                bg_q <= bg_nx;
            end

            if (rd_release) begin
                fg_q <= fg_nx;
            end

            cnt_q <= cnt_q + 3'(rx_shift) - 3'(rd_release);

            // Set beats clear
            if (rx_drop) begin
                rx_ovr_q <= 1'b1;
            end else if (i_wr && i_addr == ADDR_RX_FLAG && i_wdata[RXF_OVR]) begin
                rx_ovr_q <= 1'b0;
            end
        end
    end

    // ********************************************************
    // Read mux
    // ********************************************************
    // Closed windows read zero
    wire [7:0] tx_rd = sel_ok ? tx_mem_q[sel_idx][win_idx] : 8'h00;
    wire [7:0] rx_rd = (rxfull && win_idx < 4'(RX_BYTES)) ? rx_mem_q[fg_q][win_idx] : 8'h00;
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (tx_win) begin
            rd_mux = tx_rd;
        end else if (rx_win) begin
            rd_mux = rx_rd;
        end else begin
            case (i_addr)
                ADDR_CTRL: rd_mux = ctrl_q;
                ADDR_TX_FLAG: rd_mux = {5'h0, tx_empty_flag_q};
                ADDR_ABORT_REQ: rd_mux = {5'h0, abort_request_q};
                ADDR_ABORT_ACK: rd_mux = {5'h0, abort_acknowledge_q};
                ADDR_TX_SEL: rd_mux = {5'h0, tx_buffer_select_reg_q};
                ADDR_RX_FLAG: rd_mux = {6'h0, rx_ovr_q, rxfull};
                ADDR_TIMER_LO: rd_mux = timer_q[7:0];
                ADDR_TIMER_HI: rd_mux = timer_q[15:8];
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // ********************************************************
    // Output registers
    // ********************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
            tx_byte_q <= 8'h00;
            tx_irq_q <= 1'b0;
            rx_irq_q <= 1'b0;
            ovr_irq_q <= 1'b0;
        end else begin
            // Stands one cycle only
            rdata_q <= i_rd ? rd_mux : 8'h00;

            tx_byte_q <= tx_mem_q[act_q][i_txrd_idx];

            tx_irq_q <= sent || (abort_now != 3'h0);
            rx_irq_q <= rx_shift;
            ovr_irq_q <= rx_drop;
        end
    end


    // Ports from registers
    assign o_rdata = rdata_q;
    assign o_tx_byte = tx_byte_q;
    assign o_tx_req = st_q[1];                      // SEND alone has bit 1 set
    assign o_receiving = recv_q;
    assign o_tx_irq = tx_irq_q;
    assign o_rx_irq = rx_irq_q;
    assign o_ovr_irq = ovr_irq_q;
    assign o_init_mode = ctrl_q[CTRL_INIT];
endmodule

// file: dv/cmb_chk.sv
// Checker: concurrent assertions on the buffer manager ports
`timescale 1ns/1ps
module cmb_chk (
    input wire logic i_clock,        // Clock
    input wire logic i_rst,          // Sync reset
    input wire logic [7:0] i_addr,   // Register address
    input wire logic i_rd,           // Read strobe
    input wire logic [7:0] o_rdata,  // Read data
    input wire logic i_sof,          // Start of frame
    input wire logic i_arb_lost,     // Lost arbitration
    input wire logic i_tx_error,     // Send error
    input wire logic i_tx_done,      // Own frame acknowledged
    input wire logic i_rx_ok,        // Frame complete
    input wire logic i_rx_accept,    // Filter hit
    input wire logic i_rx_own,       // Own frame
    input wire logic o_tx_req,       // Sending
    input wire logic o_receiving,    // Receiver mode
    input wire logic o_tx_irq,       // Transmit event
    input wire logic o_rx_irq,       // Receive event
    input wire logic o_ovr_irq,      // Overrun event
    input wire logic o_init_mode     // Init mode
);
    import cmb_pkg::*;
    // ********************************************************
    // Port relations
    // ********************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside answer cycle");
    chk_timer_init: assert property ($past(i_rd) && $past(i_addr) == ADDR_TIMER_LO
        && $past(o_init_mode) && $past(o_init_mode, 2) |-> o_rdata == 8'h00)
        else $error("timer not zero in init mode");
    chk_req_at_sof: assert property ($rose(o_tx_req) |-> $past(i_sof))
        else $error("send started without start of frame");
    chk_tx_event: assert property (o_tx_req && i_tx_done |=> o_tx_irq)
        else $error("no transmit event after done");
    chk_send_ends: assert property (o_tx_req && (i_tx_done || i_tx_error || i_arb_lost)
        |=> !o_tx_req)
        else $error("send held after end of frame");
    chk_lost_rx: assert property (o_tx_req && i_arb_lost |=> o_receiving)
        else $error("not receiving after lost arbitration");
    chk_rx_event: assert property (i_rx_ok && i_rx_accept && !i_rx_own
        |=> o_rx_irq || o_ovr_irq)
        else $error("accepted frame gave no event");
    chk_reject_quiet: assert property (i_rx_ok && !i_rx_accept |=> !o_rx_irq && !o_ovr_irq)
        else $error("rejected frame gave an event");
    // Main scenarios reached
    cover property (o_tx_irq);
    cover property (o_ovr_irq);
    cover property (o_receiving && !o_tx_req);
endmodule
bind cmb_buffer_manager cmb_chk cmb_chk_inst (.i_clock, .i_rst, .i_addr, .i_rd, .o_rdata,
    .i_sof, .i_arb_lost, .i_tx_error, .i_tx_done, .i_rx_ok, .i_rx_accept, .i_rx_own,
    .o_tx_req, .o_receiving, .o_tx_irq, .o_rx_irq, .o_ovr_irq, .o_init_mode);

// file: dv/cmb_can_node.sv
// Partner model: remote CAN nodes driving the link side
`timescale 1ns/1ps
module cmb_can_node (
    input wire logic i_clock,     // Clock
    output logic o_sof,           // Start of frame
    output logic o_arb_lost,      // Lost arbitration
    output logic o_tx_error,      // Send error
    output logic o_tx_done,       // Acknowledge of own frame
    output logic o_rx_we,         // Byte strobe
    output logic [3:0] o_rx_idx,  // Byte index
    output logic [7:0] o_rx_byte, // Byte value
    output logic o_rx_ok,         // Frame complete
    output logic o_rx_accept,     // Filter hit
    output logic o_rx_own         // Own frame
);
    // Quiet link at time zero
    initial {o_sof, o_arb_lost, o_tx_error, o_tx_done, o_rx_we, o_rx_idx, o_rx_byte,
        o_rx_ok, o_rx_accept, o_rx_own} = '0;
    // One-cycle bus event: 0 sof, 1 lost, 2 error, 3 done
    task ev(input int k);
        @(posedge i_clock);
        {o_tx_done, o_tx_error, o_arb_lost, o_sof} <= 4'(1 << k);
        @(posedge i_clock);
        {o_tx_done, o_tx_error, o_arb_lost, o_sof} <= 4'h0;
    endtask
    // Whole frame, bytes first, verdict two cycles after the last byte
    task rx_frame(input logic [119:0] m, input logic acc, input logic own);
        for (int i = 0; i < 15; i++) begin
            @(posedge i_clock);
            {o_rx_we, o_rx_idx, o_rx_byte} <= {1'b1, 4'(i), m[8*i +: 8]};
        end
        @(posedge i_clock);
        {o_rx_we, o_rx_byte} <= {1'b0, ~o_rx_byte};
        @(posedge i_clock);
        {o_rx_ok, o_rx_accept, o_rx_own} <= {1'b1, acc, own};
        @(posedge i_clock);
        // Released levels flip so stale values never look valid
        {o_rx_ok, o_rx_accept, o_rx_own} <= {1'b0, ~acc, ~own};
    endtask
endmodule

// file: dv/tb_top.sv
// Testbench: self-checking run of the CAN message buffer manager
`timescale 1ns/1ps
module tb_top;
    import cmb_pkg::*;
    logic i_clock, i_rst, i_wr, i_rd, i_bit_tick, i_sof, i_arb_lost, i_tx_error, i_tx_done;
    logic i_rx_we, i_rx_ok, i_rx_accept, i_rx_own;
    logic o_tx_req, o_receiving, o_tx_irq, o_rx_irq, o_ovr_irq, o_init_mode;
    logic [7:0] i_addr, i_wdata, o_rdata, o_tx_byte, i_rx_byte;
    logic [3:0] i_txrd_idx, i_rx_idx;
    logic [7:0] local_priority [3];
    logic [127:0] msg [5];
    logic [2:0] ready;
    int bad_count = 0;
    int n_checks = 0;
    int seed = 76;
    int cyc = 0;
    int e;
    cmb_buffer_manager cmb_buffer_manager_inst (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_bit_tick, .i_sof, .i_arb_lost, .i_tx_error, .i_tx_done, .i_rx_we,
        .i_rx_idx, .i_rx_byte, .i_rx_ok, .i_rx_accept, .i_rx_own, .i_txrd_idx, .o_tx_byte,
        .o_tx_req, .o_receiving, .o_tx_irq, .o_rx_irq, .o_ovr_irq, .o_init_mode);
    cmb_can_node cmb_can_node_inst (.i_clock, .o_sof(i_sof), .o_arb_lost(i_arb_lost),
        .o_tx_error(i_tx_error), .o_tx_done(i_tx_done), .o_rx_we(i_rx_we),
        .o_rx_idx(i_rx_idx), .o_rx_byte(i_rx_byte), .o_rx_ok(i_rx_ok),
        .o_rx_accept(i_rx_accept), .o_rx_own(i_rx_own));
    // ********************************************************
    // Clock, watchdog and helpers
    // ********************************************************
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    // Whole run is about 66k cycles, mostly the timer wrap
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            stop_test;
        end
    end
    task stop_test;
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        chk(o_rdata, exp);
    endtask
    task ticks(input int n);
        repeat (n) @(posedge i_clock) i_bit_tick <= 1'b1;
        @(posedge i_clock);
        i_bit_tick <= 1'b0;
    endtask
    // Lowest priority value wins, strict compare keeps lower index on ties
    function automatic int best(input logic [2:0] m);
        int b;
        b = -1;
        for (int i = 0; i < NUM_TX; i++)
            if (m[i] && (b < 0 || local_priority[i] < local_priority[b])) b = i;
        return b;
    endfunction
    task load(input int b);
        wr(ADDR_TX_SEL, 8'(1 << b));
        wr(ADDR_TX_WIN, 8'(8'hA0 + b));
        wr(ADDR_TX_WIN + 8'(IDX_LOCAL_PRIORITY), local_priority[b]);
    endtask
    // Start of frame, then the chosen buffer must be on the wire
    task go(input int b);
        cmb_can_node_inst.ev(0);
        i_txrd_idx <= 4'h0;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        chk(o_tx_req, 16'h1);
        chk(o_tx_byte, 16'(8'hA0 + b));
        @(posedge i_clock) i_txrd_idx <= IDX_LOCAL_PRIORITY;
        @(posedge i_clock);
        @(negedge i_clock);
        chk(o_tx_byte, 16'(local_priority[b]));
    endtask
    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        {i_rst, i_wr, i_rd, i_bit_tick, i_addr, i_wdata, i_txrd_idx} = {1'b1, 23'h0};
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_TX_FLAG, 8'(TX_FLAG_RST));
        ticks(10);
        rd(ADDR_TIMER_LO, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        ticks(65541);
        rd(ADDR_TIMER_LO, 8'h05);
        rd(ADDR_TIMER_HI, 8'h00);
        chk(o_init_mode, 16'h0);
        rd(8'h10, 8'h00);
        // Random priorities, then all equal
        for (int r = 0; r < 2; r++) begin
            for (int b = 0; b < NUM_TX; b++) begin
                local_priority[b] = (r == 1) ? 8'h40 : 8'($random(seed));
                load(b);
            end
            wr(ADDR_TX_FLAG, 8'h07);
            ready = 3'h7;
            repeat (2) @(posedge i_clock);
            while (ready != 3'h0) begin
                e = best(ready);
                go(e);
                cmb_can_node_inst.ev(1);
                go(e);
                cmb_can_node_inst.ev(2);
                go(e);
                cmb_can_node_inst.ev(3);
                ready[e] = 1'b0;
                rd(ADDR_TX_FLAG, {5'h0, ~ready});
            end
            rd(ADDR_ABORT_ACK, 8'h00);
        end
        wr(ADDR_TX_SEL, 8'h01);
        rd(ADDR_TX_WIN + 8'(IDX_STAMP_LO), 8'h05);
        wr(ADDR_TX_WIN + 8'(IDX_STAMP_LO), 8'hFF);
        rd(ADDR_TX_WIN + 8'(IDX_STAMP_LO), 8'h05);
        rd(ADDR_TX_WIN + 8'(IDX_STAMP_HI), 8'h00);
        // Abort while waiting, then abort refused in flight
        load(0);
        wr(ADDR_TX_FLAG, 8'h01);
        wr(ADDR_ABORT_REQ, 8'h01);
        repeat (3) @(posedge i_clock);
        rd(ADDR_TX_FLAG, 8'h07);
        rd(ADDR_ABORT_ACK, 8'h01);
        load(0);
        wr(ADDR_TX_FLAG, 8'h01);
        rd(ADDR_TX_WIN, 8'h00);
        go(0);
        wr(ADDR_ABORT_REQ, 8'h01);
        rd(ADDR_TX_FLAG, 8'h06);
        cmb_can_node_inst.ev(3);
        rd(ADDR_ABORT_ACK, 8'h00);
        // Receive: rejected, own, looped own, three more, one overrun
        for (int q = 0; q < 5; q++)
            msg[q] = {$random(seed), $random(seed), $random(seed), $random(seed)};
        cmb_can_node_inst.rx_frame(msg[4][119:0], 1'b0, 1'b0);
        cmb_can_node_inst.rx_frame(msg[4][119:0], 1'b1, 1'b1);
        rd(ADDR_RX_FLAG, 8'h00);
        wr(ADDR_CTRL, 8'h05);
        for (int q = 0; q < 5; q++) begin
            if (q == 1) wr(ADDR_CTRL, 8'h01);
            cmb_can_node_inst.rx_frame(msg[q][119:0], 1'b1, q == 0);
        end
        rd(ADDR_RX_FLAG, 8'h03);
        load(1);
        wr(ADDR_TX_FLAG, 8'h02);
        repeat (2) @(posedge i_clock);
        go(1);
        cmb_can_node_inst.ev(3);
        for (int q = 0; q < 4; q++) begin
            for (int i = 0; i < 13; i++)
                rd(ADDR_RX_WIN + 8'(i), msg[q][8*i +: 8]);
            rd(ADDR_RX_WIN + 8'(RX_STAMP_LO), 8'h05);
            wr(ADDR_RX_FLAG, 8'h01);
        end
        rd(ADDR_RX_FLAG, 8'h02);
        rd(ADDR_RX_WIN, 8'h00);
        wr(ADDR_RX_FLAG, 8'h02);
        cmb_can_node_inst.rx_frame(msg[4][119:0], 1'b1, 1'b0);
        rd(ADDR_RX_FLAG, 8'h01);
        wr(ADDR_CTRL, 8'h03);
        repeat (2) @(posedge i_clock);
        rd(ADDR_TIMER_LO, 8'h00);
        chk(o_init_mode, 16'h1);
        stop_test;
    end
endmodule
